// ===== dpram_port_host.v
// Functional notes
// - write line stays high whenever the address lines change
// - write line stays high for the whole of every read
// - memory access: memory select low, flag select high, lane selects separate
// - flag access: memory select high throughout, flag select is the chip select
// - never drive data lines while the device may still drive them
// - slave write: hold write line low a release time after contention ends
// - after flag write, drop flag select or output enable before reading
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "dpram_host_consts.vh"

module dpram_port_host #(
    parameter ADDR_W = 16,
    parameter DATA_W = 16
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg [ADDR_W-1:0] ram_addr,
    output reg mem_select_n,
    output reg flag_select_n,
    output reg high_lane_select_n,
    output reg low_lane_select_n,
    output reg rw_n,
    output reg oe_n,
    output reg [DATA_W-1:0] data_out,
    output reg data_oe,
    input wire [DATA_W-1:0] data_in,
    input wire contend_n,
    input wire mailbox_int_n
);

    // cycle counts worked out wide, then cut to the counter width on purpose
    localparam integer ACCESS_CYC_I = `NS_TO_CYC(`ACCESS_TIME_NS);
    localparam integer PULSE_CYC_I = `NS_TO_CYC(`WRITE_PULSE_NS);
    localparam integer HOLD_CYC_I = `NS_TO_CYC(`SLAVE_RELEASE_HOLD_NS);
    localparam integer GAP_CYC_I = `NS_TO_CYC(`FLAG_UPDATE_GAP_NS);
    localparam [3:0] ACCESS_CYC = ACCESS_CYC_I[3:0];
    localparam [3:0] PULSE_CYC = PULSE_CYC_I[3:0];
    localparam [3:0] HOLD_CYC = HOLD_CYC_I[3:0];
    localparam [3:0] GAP_CYC = GAP_CYC_I[3:0];

    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_SETUP = 7'h02;
    localparam [6:0] S_WRITE = 7'h04;
    localparam [6:0] S_RELEASE = 7'h08;
    localparam [6:0] S_TAIL = 7'h10;
    localparam [6:0] S_GAP = 7'h20;
    localparam [6:0] S_READ = 7'h40;

    reg [6:0] state_reg;
    reg [3:0] cnt_reg;
    reg [1:0] op_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] wdata_reg;
    reg [DATA_W-1:0] rdata_reg;
    reg slave_reg;
    reg done_reg;
    reg contend_seen_reg;
    wire [1:0] pins_level;
    wire busy_level_n;
    wire int_level_n;
    wire start_req;
    wire clear_contend;
    wire busy_hit;

    // ----------------------------------------
    // pin input synchronisers
    // ----------------------------------------
    pin_sync #(
        .WIDTH(2),
        .IDLE_VAL(2'h3)
    ) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in({mailbox_int_n, contend_n}),
        .level_out(pins_level)
    );

    assign busy_level_n = pins_level[0];
    assign int_level_n = pins_level[1];

    // flag accesses only carry the latch index, upper lines held at zero
    function [ADDR_W-1:0] pin_address;
        input [1:0] op;
        input [ADDR_W-1:0] addr;
        begin
            if (op[1]) begin
                pin_address = {{(ADDR_W-`FLAG_ADDR_BITS){1'b0}}, addr[`FLAG_ADDR_BITS-1:0]};
            end else begin
                pin_address = addr;
            end
        end
    endfunction

    // ----------------------------------------
    // software port decode
    // ----------------------------------------
    assign start_req = reg_wr && (reg_addr == `REG_CMD) && reg_wdata[`CMD_START] && (state_reg == S_IDLE);
    assign clear_contend = reg_wr && (reg_addr == `REG_STATUS) && reg_wdata[`ST_CONTEND];
    // contention only counts while an access holds the port
    assign busy_hit = !busy_level_n && (state_reg != S_IDLE);

    // read data stand the cycle after the strobe
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_ADDR: reg_rdata <= addr_reg;
                `REG_WDATA: reg_rdata <= wdata_reg;
                `REG_RDATA: reg_rdata <= rdata_reg;
                `REG_STATUS: reg_rdata <= {11'h000, !busy_level_n, !int_level_n, contend_seen_reg, done_reg,
                    (state_reg != S_IDLE)};
                `REG_CONFIG: reg_rdata <= {15'h0000, slave_reg};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // config and access parameters, writable only while idle
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slave_reg <= 1'b0;
            addr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= {DATA_W{1'b0}};
        end else if (reg_wr && (state_reg == S_IDLE)) begin
            if (reg_addr == `REG_CONFIG) begin
                slave_reg <= reg_wdata[`CFG_SLAVE];
            end
            if (reg_addr == `REG_ADDR) begin
                addr_reg <= reg_wdata[ADDR_W-1:0];
            end
            if (reg_addr == `REG_WDATA) begin
                wdata_reg <= reg_wdata[DATA_W-1:0];
            end
        end
    end

    // sticky contention: a new hit beats a clear in the same cycle
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            contend_seen_reg <= 1'b0;
        end else if (busy_hit) begin
            contend_seen_reg <= 1'b1;
        end else if (clear_contend) begin
            contend_seen_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // pin sequencer
    // ----------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            op_reg <= `OP_MEM_READ;
            rdata_reg <= {DATA_W{1'b0}};
            done_reg <= 1'b0;
            ram_addr <= {ADDR_W{1'b0}};
            mem_select_n <= 1'b1;
            flag_select_n <= 1'b1;
            high_lane_select_n <= 1'b1;
            low_lane_select_n <= 1'b1;
            rw_n <= 1'b1;
            oe_n <= 1'b1;
            data_out <= {DATA_W{1'b0}};
            data_oe <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start_req) begin
                        op_reg <= reg_wdata[`CMD_OP_HI:`CMD_OP_LO];
                        done_reg <= 1'b0;
                        // address moves only here, with the write line high
                        ram_addr <= pin_address(reg_wdata[`CMD_OP_HI:`CMD_OP_LO], addr_reg);
                        mem_select_n <= reg_wdata[`CMD_OP_HI];
                        flag_select_n <= !reg_wdata[`CMD_OP_HI];
                        high_lane_select_n <= !reg_wdata[`CMD_HIGH_LANE];
                        low_lane_select_n <= !reg_wdata[`CMD_LOW_LANE];
                        if (reg_wdata[`CMD_OP_LO]) begin
                            state_reg <= S_SETUP;
                        end else begin
                            oe_n <= 1'b0;
                            cnt_reg <= ACCESS_CYC;
                            state_reg <= S_READ;
                        end
                    end
                end
                S_SETUP: begin
                    // output enable stays high in writes, so the bus is ours to drive
                    rw_n <= 1'b0;
                    data_oe <= 1'b1;
                    data_out <= op_reg[1] ? {{(DATA_W-1){1'b0}}, wdata_reg[0]} : wdata_reg;
                    cnt_reg <= PULSE_CYC;
                    state_reg <= S_WRITE;
                end
                S_WRITE: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else if (slave_reg) begin
                        cnt_reg <= HOLD_CYC;
                        state_reg <= S_RELEASE;
                    end else begin
                        state_reg <= S_TAIL;
                    end
                end
                S_RELEASE: begin
                    // restart the hold for as long as contention is seen
                    if (!busy_level_n) begin
                        cnt_reg <= HOLD_CYC;
                    end else if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        state_reg <= S_TAIL;
                    end
                end
                S_TAIL: begin
                    rw_n <= 1'b1;
                    cnt_reg <= GAP_CYC;
                    state_reg <= S_GAP;
                end
                S_READ: begin
                    // rw_n never leaves high in this state
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else if (!busy_level_n && !op_reg[1]) begin
                        cnt_reg <= ACCESS_CYC;
                    end else begin
                        rdata_reg <= data_in;
                        cnt_reg <= GAP_CYC;
                        state_reg <= S_GAP;
                    end
                end
                S_GAP: begin
                    // selects and output enable high before any next access
                    mem_select_n <= 1'b1;
                    flag_select_n <= 1'b1;
                    oe_n <= 1'b1;
                    high_lane_select_n <= 1'b1;
                    low_lane_select_n <= 1'b1;
                    data_oe <= 1'b0;
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        done_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== dpram_host_consts.vh
`ifndef DPRAM_HOST_CONSTS_VH
`define DPRAM_HOST_CONSTS_VH

// ----------------------------------------
// software register indices
// ----------------------------------------
`define REG_CMD 3'h0
`define REG_ADDR 3'h1
`define REG_WDATA 3'h2
`define REG_RDATA 3'h3
`define REG_STATUS 3'h4
`define REG_CONFIG 3'h5

// ----------------------------------------
// command word fields
// ----------------------------------------
`define CMD_START 0
`define CMD_OP_LO 1
`define CMD_OP_HI 2
`define CMD_LOW_LANE 3
`define CMD_HIGH_LANE 4
`define OP_MEM_READ 2'h0
`define OP_MEM_WRITE 2'h1
`define OP_FLAG_READ 2'h2
`define OP_FLAG_WRITE 2'h3

// ----------------------------------------
// status and config fields
// ----------------------------------------
`define ST_ACTIVE 0
`define ST_DONE 1
`define ST_CONTEND 2
`define ST_MAILBOX 3
`define ST_BUSY_PIN 4
`define CFG_SLAVE 0

// ----------------------------------------
// flag latch addressing
// ----------------------------------------
`define FLAG_ADDR_BITS 3

// ----------------------------------------
// timing, slower speed grade, in ns
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define ACCESS_TIME_NS 20
`define WRITE_PULSE_NS 15
`define SLAVE_RELEASE_HOLD_NS 15
`define FLAG_UPDATE_GAP_NS 10
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== pin_sync.v
`timescale 1ns/1ps

// three-stage synchroniser; output follows once stages two and three agree
module pin_sync #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] IDLE_VAL = {WIDTH{1'b1}}
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    integer i;

    // ----------------------------------------
    // stage chain, stage one feeds stage two only
    // ----------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= IDLE_VAL;
            s2_reg <= IDLE_VAL;
            s3_reg <= IDLE_VAL;
            level_out <= IDLE_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level_out[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule

// ===== dpram_dev_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// one port of the shared ram, behavioural
// ----------------------------------------
module dpram_dev_model (
    input wire [15:0] ram_addr,
    input wire mem_select_n,
    input wire flag_select_n,
    input wire high_lane_select_n,
    input wire low_lane_select_n,
    input wire rw_n,
    input wire oe_n,
    input wire [15:0] data_out,
    input wire busy_n,
    input wire post,
    output logic [15:0] data_in,
    output wire contend_n,
    output logic mailbox_int_n
);
    logic [15:0] mem [0:65535];
    logic [15:0] v;
    logic [15:0] r;
    // fixed array cleared at start, so unwritten words read as zero
    initial for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [7:0] own = 8'h00;
    wire mem_on = !mem_select_n && flag_select_n;
    wire flag_on = !flag_select_n && mem_select_n;
    // master role: flag decided here, bench plays the other port
    assign contend_n = busy_n;
    initial mailbox_int_n = 1'b1;
    // store at write end, lanes apart
    always @(posedge rw_n) begin
        v = mem[ram_addr];
        if (mem_on && !high_lane_select_n) v[15:8] = data_out[15:8];
        if (mem_on && !low_lane_select_n) v[7:0] = data_out[7:0];
        if (mem_on) mem[ram_addr] = v;
        if (flag_on) own[ram_addr[2:0]] = !data_out[0];
    end
    // the other port posts to our mailbox; our own read clears it
    always @(posedge post) mailbox_int_n = 1'b0;
    always @(negedge oe_n) #1 if (mem_on && ram_addr == 16'hFFFF) mailbox_int_n = 1'b1;
    always @(posedge oe_n) last = data_in;
    // released lines show the inverse, so a stale value cannot pass
    always @* begin
        r = mem[ram_addr];
        data_in = ~last;
        if (!oe_n && rw_n && flag_on) data_in = {16{!own[ram_addr[2:0]]}};
        if (!oe_n && rw_n && mem_on) begin
            data_in = {high_lane_select_n ? ~last[15:8] : r[15:8], low_lane_select_n ? ~last[7:0] : r[7:0]};
        end
    end
endmodule

// ===== dpram_port_host_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// pin ordering checks on the host side
// ----------------------------------------
module dpram_port_host_monitor #(
    parameter ADDR_W = 16,
    parameter DATA_W = 16
) (
    input wire clk_sys,
    input wire arst_n,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [ADDR_W-1:0] ram_addr,
    input wire mem_select_n,
    input wire flag_select_n,
    input wire rw_n,
    input wire oe_n,
    input wire data_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    addr_hold_a: assert property (!rw_n |-> $stable(ram_addr))
        else $error("address moved inside a write");
    read_rw_a: assert property ($fell(oe_n) |-> (rw_n && !oe_n)[*4])
        else $error("read cut short or write line low");
    mem_cs_a: assert property (!mem_select_n |-> flag_select_n)
        else $error("both selects low");
    flag_cs_a: assert property (!flag_select_n |-> mem_select_n)
        else $error("memory select low in flag access");
    pulse_len_a: assert property ($fell(rw_n) |-> !rw_n[*3])
        else $error("write pulse short");
    sel_first_a: assert property ($fell(rw_n) |-> !($past(mem_select_n) && $past(flag_select_n)))
        else $error("select not ahead of write line");
    drive_wr_a: assert property (data_oe |-> oe_n && (!rw_n || !$past(rw_n)))
        else $error("data driven outside write");
    flag_gap_a: assert property ($rose(flag_select_n) |-> flag_select_n[*2])
        else $error("flag select gap short");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside answer cycle");
endmodule

// ===== dpram_port_host_tb.sv
`timescale 1ns/1ps
`include "dpram_host_consts.vh"
module dpram_port_host_tb;
    logic clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, busy_n = 1, post = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, ram_addr, data_out, data_in, d;
    logic mem_select_n, flag_select_n, high_lane_select_n, low_lane_select_n;
    logic rw_n, oe_n, data_oe, contend_n, mailbox_int_n;
    int err_count = 0, check_count = 0, n;
    always #2.5 clk_sys = ~clk_sys;
    dpram_port_host dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_addr(ram_addr),
        .mem_select_n(mem_select_n), .flag_select_n(flag_select_n), .high_lane_select_n(high_lane_select_n),
        .low_lane_select_n(low_lane_select_n), .rw_n(rw_n), .oe_n(oe_n), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .contend_n(contend_n), .mailbox_int_n(mailbox_int_n));
    dpram_dev_model dev_u (.ram_addr(ram_addr), .mem_select_n(mem_select_n), .flag_select_n(flag_select_n),
        .high_lane_select_n(high_lane_select_n), .low_lane_select_n(low_lane_select_n), .rw_n(rw_n),
        .oe_n(oe_n), .data_out(data_out), .busy_n(busy_n), .post(post), .data_in(data_in),
        .contend_n(contend_n), .mailbox_int_n(mailbox_int_n));
    // ----------------------------------------
    // bus cycles and comparison
    // ----------------------------------------
    task automatic chk(input [15:0] got, input [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [2:0] a, input [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [2:0] a, output [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        // read data stand only in the cycle after the strobe
        #1 v = reg_rdata;
    endtask
    // bounded poll, so a stuck sequencer shows up as a mismatch
    task automatic wait_done();
        for (n = 0; n < 40; n++) begin
            rd(`REG_STATUS, d);
            if (d[`ST_DONE] === 1'b1) return;
        end
        chk(16'hDEAD, 16'h0000);
    endtask
    task automatic go(input [1:0] op, input [1:0] lanes, input [15:0] a, input [15:0] v);
        wr(`REG_ADDR, a);
        wr(`REG_WDATA, v);
        wr(`REG_CMD, {11'h000, lanes, op, 1'b1});
        wait_done();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic regs_test();
        chk({mem_select_n, flag_select_n, rw_n, oe_n, data_oe}, 16'h001E);
        rd(3'h6, d); chk(d, 16'h0000);
        rd(`REG_STATUS, d); chk(d, 16'h0000);
        wr(`REG_ADDR, 16'h0F0F); rd(`REG_ADDR, d); chk(d, 16'h0F0F);
    endtask
    task automatic mem_test();
        go(`OP_MEM_WRITE, 2'h3, 16'hFFFE, 16'hA55A);
        go(`OP_MEM_READ, 2'h3, 16'hFFFE, 0); rd(`REG_RDATA, d); chk(d, 16'hA55A);
        go(`OP_MEM_WRITE, 2'h2, 16'hFFFE, 16'h3C00);
        go(`OP_MEM_READ, 2'h3, 16'hFFFE, 0); rd(`REG_RDATA, d); chk(d, 16'h3C5A);
        go(`OP_MEM_READ, 2'h1, 16'hFFFE, 0); rd(`REG_RDATA, d); chk(d[7:0], 8'h5A);
    endtask
    task automatic flag_test();
        go(`OP_FLAG_WRITE, 2'h1, 16'h0003, 16'hFFFE);
        go(`OP_FLAG_READ, 2'h1, 16'h0003, 0); rd(`REG_RDATA, d); chk(d, 16'h0000);
        go(`OP_FLAG_READ, 2'h1, 16'h0004, 0); rd(`REG_RDATA, d); chk(d, 16'hFFFF);
        go(`OP_FLAG_WRITE, 2'h1, 16'h0003, 16'h0001);
        go(`OP_FLAG_READ, 2'h1, 16'h0003, 0); rd(`REG_RDATA, d); chk(d, 16'hFFFF);
    endtask
    task automatic mailbox_test();
        post <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(`REG_STATUS, d); chk(d[`ST_MAILBOX], 1'b1);
        go(`OP_MEM_READ, 2'h3, 16'hFFFF, 0);
        repeat (6) @(posedge clk_sys);
        rd(`REG_STATUS, d); chk(d[`ST_MAILBOX], 1'b0);
    endtask
    // slave write must outlast the busy input by the release hold
    task automatic slave_test();
        wr(`REG_CONFIG, 16'h0001);
        wr(`REG_ADDR, 16'h0100);
        wr(`REG_WDATA, 16'h1234);
        busy_n <= 1'b0;
        wr(`REG_CMD, 16'h001B);
        repeat (12) @(posedge clk_sys);
        #1 chk(rw_n, 1'b0);
        @(posedge clk_sys);
        busy_n <= 1'b1;
        for (n = 0; n < 20 && rw_n !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(n >= `NS_TO_CYC(`SLAVE_RELEASE_HOLD_NS) && n < 20, 1'b1);
        wait_done();
        rd(`REG_STATUS, d); chk(d[`ST_CONTEND], 1'b1);
        wr(`REG_STATUS, 16'h0004); rd(`REG_STATUS, d); chk(d[`ST_CONTEND], 1'b0);
        go(`OP_MEM_READ, 2'h3, 16'h0100, 0); rd(`REG_RDATA, d); chk(d, 16'h1234);
        // a contended read waits until the busy input goes high again
        busy_n <= 1'b0;
        wr(`REG_CMD, 16'h0019);
        repeat (10) @(posedge clk_sys);
        rd(`REG_STATUS, d); chk(d[`ST_ACTIVE], 1'b1);
        busy_n <= 1'b1;
        wait_done();
        rd(`REG_RDATA, d); chk(d, 16'h1234);
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        regs_test();
        mem_test();
        flag_test();
        mailbox_test();
        slave_test();
        conclude();
    end
    // all scenarios need well under 2000 cycles
    initial begin
        #50000;
        err_count++;
        conclude();
    end
endmodule
bind dpram_port_host dpram_port_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_u (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_addr(ram_addr), .mem_select_n(mem_select_n),
    .flag_select_n(flag_select_n), .rw_n(rw_n), .oe_n(oe_n), .data_oe(data_oe));
